// [fcr_pkg.sv]
// Purpose: Constants for the function configuration register block
// Assumes: 48-bit register split over two AXI4-Lite words
// Notes: Field positions refer to the 48-bit register
package fcr_pkg;
	localparam int REG_W = 48;
	localparam logic [3:0] OFS_LO = 4'h0;
	localparam logic [3:0] OFS_HI = 4'h4;
	localparam logic [3:0] OFS_STAT = 4'h8;
	localparam logic [47:0] RST_VAL = 48'h0800_0540_403C;
	localparam int B_CUTOFF = 0;
	localparam int B_MAX_CURRENT_RANGE = 1;
	localparam int B_SCANREV = 14;
	localparam int B_FINE = 16;
	localparam int B_OFFSLEW = 19;
	localparam int B_ONSLEW = 22;
	localparam int B_COARSE = 32;
	localparam int B_DIM = 35;
	localparam int B_DECPL = 39;
	localparam int B_BOOST = 40;
	localparam int B_BOOST_EN = 44;
	localparam int LINES_PER_DEV = 16;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [fcr_decode.sv]
// Purpose: Decode function configuration fields into control outputs
// Assumes: Register image from the bus slave, same clock
// Notes: Pure combinational decode
`timescale 1ns/1ps
`default_nettype none
module fcr_decode (
	input wire logic [47:0] cfg_in,
	input wire logic read_reply_in,
	input wire logic is_tail_in,
	input wire logic [5:0] line_in,
	output logic tail_cut_out,
	output logic [5:0] mapped_line_out,
	output logic [2:0] fine_en_out,
	output logic [2:0] coarse_en_out,
	output logic [4:0] dim_level_out,
	output logic [4:0] boost_level_out,
	output logic boost_active_out
);
	wire logic cut = cfg_in[fcr_pkg::B_CUTOFF];
	wire logic rev = cfg_in[fcr_pkg::B_SCANREV];
	wire logic upper = line_in[5:4] == 2'h1;
	// Cut only on tail, never during a read reply
	assign tail_cut_out = cut && is_tail_in && !read_reply_in;
	// Lines 16..31 reversed when set
	assign mapped_line_out = (rev && upper) ? {line_in[5:4], ~line_in[3:0]} : line_in;
	assign fine_en_out = cfg_in[fcr_pkg::B_FINE +: 3];
	assign coarse_en_out = cfg_in[fcr_pkg::B_COARSE +: 3];
	assign dim_level_out = {1'b0, cfg_in[fcr_pkg::B_DIM +: 4]} + 5'h01;
	assign boost_level_out = {1'b0, cfg_in[fcr_pkg::B_BOOST +: 4]} + 5'h01;
	assign boost_active_out = cfg_in[fcr_pkg::B_BOOST_EN];
endmodule
`default_nettype wire

// [fcr_top.sv]
// Purpose: Function configuration register with AXI4-Lite access
// Assumes: Single clock, synchronous active-low reset
// Notes: Low word at 0x0, upper 16 bits at 0x4, status at 0x8
`timescale 1ns/1ps
`default_nettype none
module fcr_top (
	input wire logic mclk_in,
	input wire logic reset_n_in,
	input wire logic [3:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [3:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	input wire logic read_reply_in,
	input wire logic is_tail_in,
	input wire logic [5:0] line_in,
	output logic tail_cut_out,
	output logic [5:0] mapped_line_out,
	output logic max_current_range_out,
	output logic [2:0] fine_en_out,
	output logic [2:0] coarse_en_out,
	output logic [2:0] turnoff_fast_out,
	output logic [5:0] turnon_slew_out,
	output logic [4:0] dim_level_out,
	output logic decoupling_en_out,
	output logic [4:0] boost_level_out,
	output logic boost_active_out
);
	logic [47:0] cfg_ff;
	logic [31:0] wdata_ff;
	logic [3:0] wstrb_ff;
	logic [3:0] awaddr_ff;
	logic aw_got_ff;
	logic w_got_ff;
	logic bvalid_ff;
	logic rvalid_ff;
	logic [1:0] bresp_ff;
	logic [1:0] rresp_ff;
	logic [31:0] rdata_ff;
	logic [2:0] status_ff;
	wire logic aw_take = s_axi_awvalid_in && !aw_got_ff && !bvalid_ff;
	wire logic w_take = s_axi_wvalid_in && !w_got_ff && !bvalid_ff;
	wire logic aw_have = aw_got_ff || aw_take;
	wire logic w_have = w_got_ff || w_take;
	wire logic do_write = aw_have && w_have && !bvalid_ff;
	wire logic [3:0] wa = aw_got_ff ? awaddr_ff : s_axi_awaddr_in;
	wire logic [31:0] wd = w_got_ff ? wdata_ff : s_axi_wdata_in;
	wire logic [3:0] ws = w_got_ff ? wstrb_ff : s_axi_wstrb_in;
	wire logic wr_lo = do_write && wa == fcr_pkg::OFS_LO;
	wire logic wr_hi = do_write && wa == fcr_pkg::OFS_HI;
	wire logic wr_ok = wr_lo || wr_hi;
	wire logic ar_take = s_axi_arvalid_in && !rvalid_ff;
	wire logic [31:0] rd_mux;
	wire logic rd_ok;
	logic [47:0] nxt_cfg;
	logic [5:0] line_sync1_ff;
	logic [5:0] line_sync2_ff;
	logic [1:0] tail_sync1_ff;
	logic [1:0] tail_sync2_ff;

	// Per-byte write with strobes
	always_comb begin
		nxt_cfg = cfg_ff;
		for (int i = 0; i < 4; i++) begin
			if (wr_lo && ws[i]) begin
				nxt_cfg[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		for (int j = 0; j < 2; j++) begin
			if (wr_hi && ws[j]) begin
				nxt_cfg[32 + j*8 +: 8] = wd[j*8 +: 8];
			end
		end
	end

	assign rd_ok = s_axi_araddr_in == fcr_pkg::OFS_LO || s_axi_araddr_in == fcr_pkg::OFS_HI ||
		s_axi_araddr_in == fcr_pkg::OFS_STAT;
	assign rd_mux = (s_axi_araddr_in == fcr_pkg::OFS_LO) ? cfg_ff[31:0] :
		(s_axi_araddr_in == fcr_pkg::OFS_HI) ? {16'h0000, cfg_ff[47:32]} :
		(s_axi_araddr_in == fcr_pkg::OFS_STAT) ? {29'h0, status_ff} : 32'h0000_0000;

	always_ff @(posedge mclk_in) begin
		if (!reset_n_in) begin
			cfg_ff <= fcr_pkg::RST_VAL;
		end else begin
			cfg_ff <= nxt_cfg;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!reset_n_in) begin
			aw_got_ff <= 1'b0;
			w_got_ff <= 1'b0;
			awaddr_ff <= 4'h0;
			wdata_ff <= 32'h0000_0000;
			wstrb_ff <= 4'h0;
		end else begin
			if (do_write) begin
				aw_got_ff <= 1'b0;
				w_got_ff <= 1'b0;
			end else begin
				if (aw_take) begin
					aw_got_ff <= 1'b1;
				end
				if (w_take) begin
					w_got_ff <= 1'b1;
				end
			end
			// Hold address and data until both halves arrive
			if (aw_take) begin
				awaddr_ff <= s_axi_awaddr_in;
			end
			if (w_take) begin
				wdata_ff <= s_axi_wdata_in;
				wstrb_ff <= s_axi_wstrb_in;
			end
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!reset_n_in) begin
			bvalid_ff <= 1'b0;
			bresp_ff <= fcr_pkg::RESP_OKAY;
		end else if (do_write) begin
			bvalid_ff <= 1'b1;
			bresp_ff <= wr_ok ? fcr_pkg::RESP_OKAY : fcr_pkg::RESP_SLVERR;
		end else if (s_axi_bready_in) begin
			bvalid_ff <= 1'b0;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!reset_n_in) begin
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
			rresp_ff <= fcr_pkg::RESP_OKAY;
		end else if (ar_take) begin
			rvalid_ff <= 1'b1;
			rdata_ff <= rd_mux;
			rresp_ff <= rd_ok ? fcr_pkg::RESP_OKAY : fcr_pkg::RESP_SLVERR;
		end else if (s_axi_rready_in) begin
			rvalid_ff <= 1'b0;
		end
	end

	// Two-flop sync of pin-side inputs
	always_ff @(posedge mclk_in) begin
		if (!reset_n_in) begin
			line_sync1_ff <= 6'h00;
			line_sync2_ff <= 6'h00;
			tail_sync1_ff <= 2'h0;
			tail_sync2_ff <= 2'h0;
		end else begin
			line_sync1_ff <= line_in;
			line_sync2_ff <= line_sync1_ff;
			tail_sync1_ff <= {read_reply_in, is_tail_in};
			tail_sync2_ff <= tail_sync1_ff;
		end
	end

	// Status registers boost active, synced tail and tail cut, one cycle behind
	always_ff @(posedge mclk_in) begin
		if (!reset_n_in) begin
			status_ff <= 3'h0;
		end else begin
			status_ff <= {boost_active_out, tail_sync2_ff[0], tail_cut_out};
		end
	end

	assign s_axi_awready_out = !aw_got_ff && !bvalid_ff;
	assign s_axi_wready_out = !w_got_ff && !bvalid_ff;
	assign s_axi_bvalid_out = bvalid_ff;
	assign s_axi_bresp_out = bresp_ff;
	assign s_axi_arready_out = !rvalid_ff;
	assign s_axi_rvalid_out = rvalid_ff;
	assign s_axi_rdata_out = rdata_ff;
	assign s_axi_rresp_out = rresp_ff;

	assign max_current_range_out = cfg_ff[fcr_pkg::B_MAX_CURRENT_RANGE];
	assign turnoff_fast_out = cfg_ff[fcr_pkg::B_OFFSLEW +: 3];
	assign turnon_slew_out = cfg_ff[fcr_pkg::B_ONSLEW +: 6];
	assign decoupling_en_out = cfg_ff[fcr_pkg::B_DECPL];

	fcr_decode fcr_decode_inst (
		.cfg_in(cfg_ff),
		.read_reply_in(tail_sync2_ff[1]),
		.is_tail_in(tail_sync2_ff[0]),
		.line_in(line_sync2_ff),
		.tail_cut_out(tail_cut_out),
		.mapped_line_out(mapped_line_out),
		.fine_en_out(fine_en_out),
		.coarse_en_out(coarse_en_out),
		.dim_level_out(dim_level_out),
		.boost_level_out(boost_level_out),
		.boost_active_out(boost_active_out)
	);

	// Assertions
	AST_CUT: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
		(cfg_ff[0] && tail_sync2_ff == 2'h1) |-> tail_cut_out)
		else $error("tail not cut");
	AST_NOCUT: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
		!cfg_ff[0] |-> !tail_cut_out)
		else $error("cut while disabled");
	AST_MAX_CURRENT_RANGE: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
		(wr_lo && ws[0]) |=> max_current_range_out == $past(wd[1]))
		else $error("current range not written");
	AST_REV: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
		(cfg_ff[14] && line_sync2_ff == 6'h10) |-> mapped_line_out == 6'h1F)
		else $error("reverse map wrong");
	AST_FWD: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
		!cfg_ff[14] |-> mapped_line_out == line_sync2_ff)
		else $error("forward map wrong");
	AST_FINE: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
		$rose(reset_n_in) |-> fine_en_out == 3'h0 && coarse_en_out == 3'h0)
		else $error("comp enables not reset");
	AST_COARSE: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
		(wr_hi && ws[0]) |=> coarse_en_out == $past(wd[2:0]))
		else $error("coarse not written");
	AST_SLEW: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
		$rose(reset_n_in) |-> turnon_slew_out == 6'h15 && turnoff_fast_out == 3'h0)
		else $error("slew reset wrong");
	AST_DIM: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
		dim_level_out == {1'b0, cfg_ff[38:35]} + 5'h01)
		else $error("dim level wrong");
	AST_BOOST: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
		boost_active_out |-> cfg_ff[44] && boost_level_out == {1'b0, cfg_ff[43:40]} + 5'h01)
		else $error("boost wrong");
	AST_BRESP: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
		do_write |=> bvalid_ff)
		else $error("no write response");

	// Field write-through checks, and no change on unmapped writes
	AST_OFFSLEW: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
		(wr_lo && ws[2]) |=> turnoff_fast_out == $past(wd[21:19]))
		else $error("turn-off slew not written");
	AST_ONSLEW: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
		(wr_lo && ws[2] && ws[3]) |=> turnon_slew_out == $past(wd[27:22]))
		else $error("turn-on slew not written");
	AST_FINE_WR: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
		(wr_lo && ws[2]) |=> fine_en_out == $past(wd[18:16]))
		else $error("fine enables not written");
	AST_DECPL: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
		(wr_hi && ws[0]) |=> decoupling_en_out == $past(wd[7]))
		else $error("decoupling enable not written");
	AST_NOWR_BAD: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
		(do_write && !wr_ok) |=> cfg_ff == $past(cfg_ff))
		else $error("unmapped write changed register");

	// Reset values seen on the first edge after release
	AST_DECPL_RST: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
		$rose(reset_n_in) |-> !decoupling_en_out && !boost_active_out)
		else $error("decoupling reset wrong");
	AST_DIM_RST: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
		$rose(reset_n_in) |-> dim_level_out == 5'h01 && boost_level_out == 5'h09)
		else $error("dim or boost level reset wrong");
	AST_SCAN_RST: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
		$rose(reset_n_in) |-> cfg_ff[14] && !max_current_range_out && !tail_cut_out)
		else $error("scan or range reset wrong");

	// Output cut-off, boost gating and line mapping
	AST_READ_PASS: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
		tail_sync2_ff[1] |-> !tail_cut_out)
		else $error("cut during read reply");
	AST_NOTAIL: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
		!tail_sync2_ff[0] |-> !tail_cut_out)
		else $error("cut on non-tail device");
	AST_BOOST_OFF: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
		!cfg_ff[44] |-> !boost_active_out)
		else $error("boost active while disabled");
	AST_REV_ALL: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
		(cfg_ff[14] && line_sync2_ff[5:4] == 2'h1) |-> mapped_line_out + line_sync2_ff == 6'h2F)
		else $error("upper lines not descending");
	AST_LOW_LINES: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
		line_sync2_ff[5:4] != 2'h1 |-> mapped_line_out == line_sync2_ff)
		else $error("lower lines remapped");

	// Response channels hold until taken; a read accept raises rvalid next cycle
	AST_BVALID_HOLD: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
		(bvalid_ff && !s_axi_bready_in) |=> bvalid_ff && $stable(bresp_ff))
		else $error("write response dropped");
	AST_RVALID_HOLD: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
		(rvalid_ff && !s_axi_rready_in) |=> rvalid_ff && $stable(rdata_ff))
		else $error("read data dropped");
	AST_RVALID: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
		ar_take |=> rvalid_ff)
		else $error("no read response");

	COV_WR: cover property (@(posedge mclk_in) wr_lo);
	COV_WR_HI: cover property (@(posedge mclk_in) wr_hi);
	COV_REV: cover property (@(posedge mclk_in) cfg_ff[14] && line_sync2_ff[5:4] == 2'h1);
	COV_RD: cover property (@(posedge mclk_in) ar_take && rd_ok);
	COV_CUT: cover property (@(posedge mclk_in) tail_cut_out);
endmodule
`default_nettype wire

// [fcr_ctrl_model.sv]
// Purpose: AXI4-Lite controller model for the configuration block
// Assumes: One clock, signals changed by NBA after a rising edge
// Notes: Tasks wr and rd are called by the testbench
`timescale 1ns/1ps
`default_nettype none
module fcr_ctrl_model (
	input wire logic clk_in,
	output logic [3:0] awaddr_out,
	output logic awvalid_out,
	input wire logic awready_in,
	output logic [31:0] wdata_out,
	output logic [3:0] wstrb_out,
	output logic wvalid_out,
	input wire logic wready_in,
	input wire logic [1:0] bresp_in,
	input wire logic bvalid_in,
	output logic bready_out,
	output logic [3:0] araddr_out,
	output logic arvalid_out,
	input wire logic arready_in,
	input wire logic [31:0] rdata_in,
	input wire logic [1:0] rresp_in,
	input wire logic rvalid_in,
	output logic rready_out
);
	initial begin
		{awaddr_out, awvalid_out, wdata_out, wstrb_out, wvalid_out, bready_out} = '0;
		{araddr_out, arvalid_out, rready_out} = '0;
	end
	task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
		bit ah;
		bit wh;
		ah = 1'b0;
		wh = 1'b0;
		@(posedge clk_in);
		awaddr_out <= a;
		wdata_out <= d;
		wstrb_out <= 4'hF;
		awvalid_out <= 1'b1;
		wvalid_out <= 1'b1;
		bready_out <= 1'b1;
		do begin
			@(posedge clk_in);
			if (!ah && awready_in) begin
				ah = 1'b1;
				awvalid_out <= 1'b0;
			end
			if (!wh && wready_in) begin
				wh = 1'b1;
				wvalid_out <= 1'b0;
			end
		end while (!(ah && wh && bvalid_in));
		r = bresp_in;
		bready_out <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk_in);
		araddr_out <= a;
		arvalid_out <= 1'b1;
		rready_out <= 1'b1;
		do @(posedge clk_in); while (!arready_in);
		arvalid_out <= 1'b0;
		do @(posedge clk_in); while (!rvalid_in);
		d = rdata_in;
		r = rresp_in;
		rready_out <= 1'b0;
	endtask
endmodule
`default_nettype wire

// [tb_fcr_top.sv]
// Purpose: Self-checking bench for the configuration register block
// Assumes: AXI4-Lite access through the controller model
// Notes: Pin inputs settle after a two-cycle sync
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
	$display("FAIL %s exp %h got %h", nm, e, g); end end
module tb_fcr_top;
	logic mclk = 0, reset_n = 0, rr = 0, tl = 0;
	logic [5:0] ln = '0;
	wire logic [3:0] awa, ara, wst;
	wire logic [31:0] wd, rdt;
	wire logic [1:0] br, rrs;
	wire logic awv, awr, wv, wr_, bv, bry, arv, arr, rv, rry, cut, max_current_range, dec, bact;
	wire logic [5:0] mln, ton;
	wire logic [2:0] fin, coa, tof;
	wire logic [4:0] dim, bst;
	int n_errors = 0, total_checks = 0;
	logic [1:0] resp;
	logic [31:0] dat;
	always #2 mclk = ~mclk;
	fcr_top fcr_top_inst (.mclk_in(mclk), .reset_n_in(reset_n), .s_axi_awaddr_in(awa),
		.s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_wdata_in(wd),
		.s_axi_wstrb_in(wst), .s_axi_wvalid_in(wv), .s_axi_wready_out(wr_),
		.s_axi_bresp_out(br), .s_axi_bvalid_out(bv), .s_axi_bready_in(bry),
		.s_axi_araddr_in(ara), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
		.s_axi_rdata_out(rdt), .s_axi_rresp_out(rrs), .s_axi_rvalid_out(rv),
		.s_axi_rready_in(rry), .read_reply_in(rr), .is_tail_in(tl), .line_in(ln),
		.tail_cut_out(cut), .mapped_line_out(mln), .max_current_range_out(max_current_range),
		.fine_en_out(fin), .coarse_en_out(coa), .turnoff_fast_out(tof),
		.turnon_slew_out(ton), .dim_level_out(dim), .decoupling_en_out(dec),
		.boost_level_out(bst), .boost_active_out(bact));
	fcr_ctrl_model fcr_ctrl_model_inst (.clk_in(mclk), .awaddr_out(awa), .awvalid_out(awv),
		.awready_in(awr), .wdata_out(wd), .wstrb_out(wst), .wvalid_out(wv), .wready_in(wr_),
		.bresp_in(br), .bvalid_in(bv), .bready_out(bry), .araddr_out(ara), .arvalid_out(arv),
		.arready_in(arr), .rdata_in(rdt), .rresp_in(rrs), .rvalid_in(rv), .rready_out(rry));
	task automatic report_and_stop();
		if (n_errors == 0 && total_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic wchk(input logic [3:0] a, input logic [31:0] d, input logic [1:0] e);
		fcr_ctrl_model_inst.wr(a, d, resp);
		`CHK("bresp", e, resp)
	endtask
	task automatic rchk(input logic [3:0] a, input logic [31:0] e);
		fcr_ctrl_model_inst.rd(a, dat, resp);
		`CHK("rresp", fcr_pkg::RESP_OKAY, resp)
		`CHK("rdata", e, dat)
	endtask
	task automatic outs(input logic i, input logic [2:0] f, c, t, input logic [5:0] o,
		input logic [4:0] dl, input logic de, input logic [4:0] bl, input logic ba);
		#1;
		`CHK("max_current_range", i, max_current_range)
		`CHK("fine", f, fin)
		`CHK("coarse", c, coa)
		`CHK("turnoff", t, tof)
		`CHK("turnon", o, ton)
		`CHK("dim", dl, dim)
		`CHK("decpl", de, dec)
		`CHK("boost", bl, bst)
		`CHK("boost_act", ba, bact)
	endtask
	task automatic pins(input logic t, r, input logic [5:0] l);
		@(posedge mclk);
		tl <= t;
		rr <= r;
		ln <= l;
		repeat (4) @(posedge mclk);
		#1;
	endtask
	initial begin
		repeat (20000) @(posedge mclk);
		n_errors++;
		report_and_stop();
	end
	initial begin
		repeat (2) @(posedge mclk);
		reset_n <= 1'b1;
		rchk(4'h0, 32'h0540_403C);
		rchk(4'h4, 32'h0000_0800);
		outs(0, 0, 0, 0, 6'h15, 5'h01, 0, 5'h09, 0);
		wchk(4'h0, 32'h0FFF_403F, fcr_pkg::RESP_OKAY);
		wchk(4'h4, 32'h0000_1FFF, fcr_pkg::RESP_OKAY);
		rchk(4'h0, 32'h0FFF_403F);
		rchk(4'h4, 32'h0000_1FFF);
		outs(1, 7, 7, 7, 6'h3F, 5'h10, 1, 5'h10, 1);
		for (int i = 0; i < 3; i++) begin
			wchk(4'h0, 32'h403C | (32'h1 << (16 + i)) | (32'h1 << (19 + i)) | (32'h3 << (22 + 2 * i)),
				fcr_pkg::RESP_OKAY);
			wchk(4'h4, (32'h1 << i) | (32'(i * 7) << 3) | (32'(15 - i * 7) << 8), fcr_pkg::RESP_OKAY);
			outs(0, 3'(1 << i), 3'(1 << i), 3'(1 << i), 6'(3 << (2 * i)), 5'(i * 7 + 1), 0,
				5'(16 - i * 7), 0);
		end
		wchk(4'h0, 32'h0000_403D, fcr_pkg::RESP_OKAY);
		pins(1, 0, 6'h05);
		`CHK("cut", 1'b1, cut)
		`CHK("line", 6'h05, mln)
		pins(1, 1, 6'h10);
		`CHK("cut", 1'b0, cut)
		`CHK("line", 6'h1F, mln)
		pins(0, 0, 6'h1F);
		`CHK("cut", 1'b0, cut)
		`CHK("line", 6'h10, mln)
		wchk(4'h0, 32'h0000_003C, fcr_pkg::RESP_OKAY);
		pins(1, 0, 6'h14);
		`CHK("cut", 1'b0, cut)
		`CHK("line", 6'h14, mln)
		rchk(4'h8, 32'h0000_0002);
		wchk(4'hC, 32'hFFFF_FFFF, fcr_pkg::RESP_SLVERR);
		fcr_ctrl_model_inst.rd(4'hC, dat, resp);
		`CHK("rresp", fcr_pkg::RESP_SLVERR, resp)
		rchk(4'h0, 32'h0000_003C);
		report_and_stop();
	end
endmodule
`default_nettype wire
